/* hdl/arc_defs.vh */
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH
// register word indices (printed offsets kept as indices, address = 4 x index)
`define ARC_IDX_RESULT_HIGH 16'h0004
`define ARC_IDX_RESULT_LOW 16'h0005
`define ARC_IDX_COMPARE_HIGH 16'h0006
`define ARC_IDX_COMPARE_LOW 16'h0007
`define ARC_IDX_PIN_LOW 16'h309C
`define ARC_IDX_PIN_HIGH 16'h309D
`define ARC_IDX_CONFIG 16'h0008
`define ARC_ADDR_W 16
// config register fields
`define ARC_CFG_RES_LSB 0
`define ARC_CFG_CMP_EN_BIT 2
`define ARC_CFG_DEPTH_LSB 4
// resolution codes
`define ARC_RES_8 2'h0
`define ARC_RES_12 2'h1
`define ARC_RES_10 2'h2
// reset values
`define ARC_RST_BYTE 8'h00
`define ARC_RST_CFG 8'h00
// answers
`define ARC_RESP_OKAY 2'h0
`define ARC_RESP_SLVERR 2'h2
`endif

/* hdl/arc_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.vh"
module arc_regs #(
    parameter DEPTH_MAX = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire conv_done,
    input wire [11:0] conv_result,
    output reg conversion_complete_flag,
    output reg conv_restart,
    output reg results_valid,
    output reg [1:0] resolution,
    output reg compare_enable,
    output reg [2:0] fifo_depth,
    output reg cfg_written,
    output reg [11:0] pin_analog_select,
    output reg [11:0] port_oe_n_force,
    output reg [11:0] port_input_enable,
    output reg [11:0] port_pullup_enable
);
    reg [7:0] compare_high_q;
    reg [7:0] compare_low_q;
    reg [7:0] pin_low_q;
    reg [3:0] pin_high_q;
    reg [11:0] result_q;
    reg interlock_q;
    reg [11:0] fifo_mem [0:DEPTH_MAX-1];
    reg [2:0] fifo_wr_q;
    reg [2:0] fifo_rd_q;
    reg [2:0] fifo_cnt_q;
    reg have_aw_q;
    reg have_w_q;
    reg [31:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    function [15:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[17:2];
        end
    endfunction

    // shared by both FIFO pointers; wraps after the last level
    function [2:0] wrap_ptr;
        input [2:0] ptr;
        input [2:0] last;
        begin
            wrap_ptr = (ptr == last) ? 3'h0 : ptr + 3'h1;
        end
    endfunction

    function hit;
        input [31:0] addr;
        input [15:0] idx;
        begin
            hit = (addr[1:0] == 2'h0) && (addr[31:18] == 14'h0000) && (word_index(addr) == idx);
        end
    endfunction

    wire fifo_on = (fifo_depth != 3'h0);
    wire [3:0] fifo_levels = {1'b0, fifo_depth} + 4'h1;
    wire [11:0] result_now = fifo_on ? fifo_mem[fifo_rd_q] : result_q;
    // upper nibble match
    // only 12-bit results have their upper nibble compared; 10-bit ones are not
    wire cmp_hi_match = (conv_result[11:8] == compare_high_q[3:0]);
    wire cmp_lo_match = (conv_result[7:0] == compare_low_q);
    // equality is the compare condition; other modes ignore the high nibble
    wire cmp_true = (resolution == `ARC_RES_12) ? (cmp_hi_match && cmp_lo_match) : cmp_lo_match;
    wire do_write = have_aw_q && have_w_q && !s_axi_bvalid;
    wire wr_byte = do_write && wstrb_q[0];
    // write decode, one select per register
    wire sel_res_high = hit(awaddr_q, `ARC_IDX_RESULT_HIGH);
    wire sel_res_low = hit(awaddr_q, `ARC_IDX_RESULT_LOW);
    wire sel_cmp_high = hit(awaddr_q, `ARC_IDX_COMPARE_HIGH);
    wire sel_cmp_low = hit(awaddr_q, `ARC_IDX_COMPARE_LOW);
    wire sel_pin_low = hit(awaddr_q, `ARC_IDX_PIN_LOW);
    wire sel_pin_high = hit(awaddr_q, `ARC_IDX_PIN_HIGH);
    wire sel_cfg = hit(awaddr_q, `ARC_IDX_CONFIG);
    // result registers take writes silently so software sees no error
    wire sel_any = sel_res_high || sel_res_low || sel_cmp_high || sel_cmp_low ||
        sel_pin_low || sel_pin_high || sel_cfg;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    // read decode, one select per register
    wire rsel_res_high = hit(s_axi_araddr, `ARC_IDX_RESULT_HIGH);
    wire rsel_res_low = hit(s_axi_araddr, `ARC_IDX_RESULT_LOW);
    wire rsel_cmp_high = hit(s_axi_araddr, `ARC_IDX_COMPARE_HIGH);
    wire rsel_cmp_low = hit(s_axi_araddr, `ARC_IDX_COMPARE_LOW);
    wire rsel_pin_low = hit(s_axi_araddr, `ARC_IDX_PIN_LOW);
    wire rsel_pin_high = hit(s_axi_araddr, `ARC_IDX_PIN_HIGH);
    wire rsel_cfg = hit(s_axi_araddr, `ARC_IDX_CONFIG);
    wire rd_high = rd_take && rsel_res_high;
    wire rd_low = rd_take && rsel_res_low;
    wire w_cfg = wr_byte && sel_cfg;
    wire res_change = w_cfg && (wdata_q[`ARC_CFG_RES_LSB+1:`ARC_CFG_RES_LSB] != resolution);
    wire depth_change = w_cfg && (wdata_q[`ARC_CFG_DEPTH_LSB+2:`ARC_CFG_DEPTH_LSB] != fifo_depth);
    // 8-bit ignores earlier lock
    // a lock left over from 12/10-bit must not stall 8-bit results
    wire lock_on = interlock_q && (resolution != `ARC_RES_8);
    wire accept = conv_done && !lock_on && (!compare_enable || cmp_true);
    wire blocked = conv_done && lock_on;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            awaddr_q <= 32'h00000000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARC_RESP_OKAY;
        end else begin
            // readies are one-cycle pulses, so a held valid is taken once
            s_axi_awready <= !have_aw_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !have_w_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            // response waits until both address and data are in
            if (do_write) begin
                have_aw_q <= 1'b0;
                have_w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (sel_any)
                    s_axi_bresp <= `ARC_RESP_OKAY;
                else
                    s_axi_bresp <= `ARC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            compare_high_q <= `ARC_RST_BYTE;
            compare_low_q <= `ARC_RST_BYTE;
            pin_low_q <= `ARC_RST_BYTE;
            pin_high_q <= 4'h0;
            resolution <= `ARC_RES_8;
            compare_enable <= 1'b0;
            fifo_depth <= 3'h0;
            cfg_written <= 1'b0;
        end else begin
            // lets the core abort a conversion made stale by the write
            cfg_written <= wr_byte && (sel_cfg || sel_cmp_high || sel_cmp_low);
            if (do_write && wstrb_q[0]) begin
                if (hit(awaddr_q, `ARC_IDX_COMPARE_HIGH))
                    compare_high_q <= {4'h0, wdata_q[3:0]};
                if (hit(awaddr_q, `ARC_IDX_COMPARE_LOW))
                    compare_low_q <= wdata_q[7:0];
                if (hit(awaddr_q, `ARC_IDX_PIN_LOW))
                    pin_low_q <= wdata_q[7:0];
                if (hit(awaddr_q, `ARC_IDX_PIN_HIGH))
                    pin_high_q <= wdata_q[3:0];
                if (w_cfg) begin
                    resolution <= wdata_q[`ARC_CFG_RES_LSB+1:`ARC_CFG_RES_LSB];
                    compare_enable <= wdata_q[`ARC_CFG_CMP_EN_BIT];
                    fifo_depth <= wdata_q[`ARC_CFG_DEPTH_LSB+2:`ARC_CFG_DEPTH_LSB];
                end
            end
        end
    end

    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            result_q <= 12'h000;
            interlock_q <= 1'b0;
            fifo_wr_q <= 3'h0;
            fifo_rd_q <= 3'h0;
            fifo_cnt_q <= 3'h0;
            conversion_complete_flag <= 1'b0;
            conv_restart <= 1'b0;
            results_valid <= 1'b0;
            for (i = 0; i < DEPTH_MAX; i = i + 1)
                fifo_mem[i] <= 12'h000;
        end else begin
            conversion_complete_flag <= 1'b0;
            conv_restart <= blocked;
            // high read arms interlock, not in 8-bit
            if (rd_high && resolution != `ARC_RES_8)
                interlock_q <= 1'b1;
            if (rd_low)
                interlock_q <= 1'b0;
            // advance FIFO on low read
            // wraps at the last level so reads cycle through one set
            if (rd_low && fifo_on)
                fifo_rd_q <= wrap_ptr(fifo_rd_q, fifo_depth);
            if (accept) begin
                if (fifo_on) begin
                    fifo_mem[fifo_wr_q] <= conv_result;
                    // set complete at fifo_depth + 1 entries
                    // next set lands from entry zero again
                    if ({1'b0, fifo_cnt_q} + 4'h1 == fifo_levels) begin
                        fifo_cnt_q <= 3'h0;
                        fifo_wr_q <= 3'h0;
                        fifo_rd_q <= 3'h0;
                        conversion_complete_flag <= 1'b1;
                        results_valid <= 1'b1;
                    end else begin
                        fifo_cnt_q <= fifo_cnt_q + 3'h1;
                        fifo_wr_q <= wrap_ptr(fifo_wr_q, fifo_depth);
                    end
                end else begin
                    result_q <= conv_result;
                    conversion_complete_flag <= 1'b1;
                    results_valid <= 1'b1;
                end
            end
            // resolution or depth change invalidates
            // pointers restart so a stale partial set is never read
            if (res_change || depth_change) begin
                results_valid <= 1'b0;
                fifo_cnt_q <= 3'h0;
                fifo_wr_q <= 3'h0;
                fifo_rd_q <= 3'h0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ARC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `ARC_RESP_OKAY;
                if (rsel_res_high)
                    s_axi_rdata <= {28'h0000000, (resolution == `ARC_RES_8) ? 4'h0 : result_now[11:8]};
                else if (rsel_res_low)
                    s_axi_rdata <= {24'h000000, result_now[7:0]};
                else if (rsel_cmp_high)
                    s_axi_rdata <= {28'h0000000, compare_high_q[3:0]};
                else if (rsel_cmp_low)
                    s_axi_rdata <= {24'h000000, compare_low_q};
                else if (rsel_pin_low)
                    s_axi_rdata <= {24'h000000, pin_low_q};
                else if (rsel_pin_high)
                    s_axi_rdata <= {28'h0000000, pin_high_q};
                else if (rsel_cfg)
                    s_axi_rdata <= {23'h000000, interlock_q, 1'b0, fifo_depth, 1'b0, compare_enable, resolution};
                // unmapped reads answer with zero data and an error
                else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `ARC_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_analog_select <= 12'h000;
            // pins start under port control
            port_oe_n_force <= 12'h000;
            port_input_enable <= 12'hFFF;
            port_pullup_enable <= 12'hFFF;
        end else begin
            pin_analog_select <= {pin_high_q, pin_low_q};
            port_oe_n_force <= {pin_high_q, pin_low_q};
            port_input_enable <= ~{pin_high_q, pin_low_q};
            port_pullup_enable <= ~{pin_high_q, pin_low_q};
        end
    end
endmodule
`default_nettype wire

/* test/arc_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module arc_regs_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic conv_done,
    input wire logic conversion_complete_flag,
    input wire logic conv_restart,
    input wire logic results_valid,
    input wire logic [11:0] pin_analog_select,
    input wire logic [11:0] port_oe_n_force,
    input wire logic [11:0] port_input_enable,
    input wire logic [11:0] port_pullup_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence b_waiting;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    flag_after_done_a: assert property (conversion_complete_flag |-> $past(conv_done))
        else $error("complete flag without a finished conversion");
    restart_after_drop_a: assert property (conv_restart |-> $past(conv_done) && !conversion_complete_flag)
        else $error("restart without a dropped conversion");
    valid_with_flag_a: assert property ($rose(results_valid) |-> conversion_complete_flag)
        else $error("results marked valid without a load");
    // a stable select must have reached the pin controls
    pin_follow_a: assert property ($stable(pin_analog_select) [*2] |-> port_oe_n_force == pin_analog_select)
        else $error("pin output control does not follow select");
    pin_inverse_a: assert property (port_input_enable == ~port_oe_n_force && port_pullup_enable == ~port_oe_n_force)
        else $error("input or pullup enable not inverse of hi-z");
    read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    bvalid_hold_a: assert property (b_waiting |=> s_axi_bvalid)
        else $error("write answer dropped");
    arready_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
endmodule
bind arc_regs arc_regs_chk i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .conv_done, .conversion_complete_flag, .conv_restart,
    .results_valid, .pin_analog_select, .port_oe_n_force, .port_input_enable, .port_pullup_enable);
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "arc_defs.vh"
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_done;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
    logic [3:0] s_axi_wstrb;
    logic [11:0] conv_result;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conversion_complete_flag;
    wire conv_restart, results_valid, compare_enable, cfg_written;
    wire [1:0] s_axi_bresp, s_axi_rresp, resolution;
    wire [31:0] s_axi_rdata;
    wire [2:0] fifo_depth;
    wire [11:0] pin_analog_select, port_oe_n_force, port_input_enable, port_pullup_enable;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    int nflag = 0;
    int nrst = 0;
    arc_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_done, .conv_result,
        .conversion_complete_flag, .conv_restart, .results_valid, .resolution, .compare_enable, .fifo_depth,
        .cfg_written, .pin_analog_select, .port_oe_n_force, .port_input_enable, .port_pullup_enable);
    task stop_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        while (s_axi_bvalid !== 1'b1) begin
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, `ARC_RESP_OKAY);
    endtask
    task rd(input [31:0] a, input [31:0] e, input [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1) begin
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
    endtask
    task conv(input [11:0] v);
        conv_result <= v;
        conv_done <= 1'b1;
        @(posedge aclk);
        conv_done <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // timeout far above the fewer than two hundred cycles the sequence needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (conversion_complete_flag === 1'b1) nflag <= nflag + 1;
        if (conv_restart === 1'b1) nrst <= nrst + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            stop_test;
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, conv_done} = 7'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, conv_result} = 108'h0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(32'h18, 0, `ARC_RESP_OKAY);
        rd(32'h1C, 0, `ARC_RESP_OKAY);
        rd(32'hC274, 0, `ARC_RESP_OKAY);
        rd(32'h40, 0, `ARC_RESP_SLVERR);
        wr(32'h20, 32'h01);
        conv(12'hABC);
        rd(32'h10, 32'h0A, `ARC_RESP_OKAY);
        // high read arms the interlock, next result is lost
        conv(12'h123);
        rd(32'h14, 32'hBC, `ARC_RESP_OKAY);
        chk(nrst, 1);
        chk(nflag, 1);
        conv(12'h456);
        rd(32'h10, 32'h04, `ARC_RESP_OKAY);
        rd(32'h14, 32'h56, `ARC_RESP_OKAY);
        wr(32'h20, 32'h00);
        repeat (2) @(posedge aclk);
        chk(results_valid, 0);
        conv(12'h0F7);
        rd(32'h10, 32'h00, `ARC_RESP_OKAY);
        conv(12'h033);
        rd(32'h14, 32'h33, `ARC_RESP_OKAY);
        wr(32'h1C, 32'h55);
        wr(32'h20, 32'h04);
        conv(12'h066);
        rd(32'h14, 32'h33, `ARC_RESP_OKAY);
        conv(12'h055);
        rd(32'h14, 32'h55, `ARC_RESP_OKAY);
        wr(32'h18, 32'hF3);
        rd(32'h18, 32'h03, `ARC_RESP_OKAY);
        wr(32'h20, 32'h05);
        conv(12'h255);
        conv(12'h355);
        rd(32'h10, 32'h03, `ARC_RESP_OKAY);
        rd(32'h14, 32'h55, `ARC_RESP_OKAY);
        chk(nflag, 6);
        wr(32'h20, 32'h11);
        conv(12'h111);
        chk(nflag, 6);
        conv(12'h222);
        chk(nflag, 7);
        rd(32'h10, 32'h01, `ARC_RESP_OKAY);
        rd(32'h14, 32'h11, `ARC_RESP_OKAY);
        rd(32'h10, 32'h02, `ARC_RESP_OKAY);
        rd(32'h14, 32'h22, `ARC_RESP_OKAY);
        wr(32'hC270, 32'hA5);
        wr(32'hC274, 32'hFF);
        rd(32'hC274, 32'h0F, `ARC_RESP_OKAY);
        rd(32'hC270, 32'hA5, `ARC_RESP_OKAY);
        chk(pin_analog_select, 12'hFA5);
        chk(port_oe_n_force, 12'hFA5);
        chk(port_input_enable, 12'h05A);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(32'hC270, 0, `ARC_RESP_OKAY);
        rd(32'h18, 0, `ARC_RESP_OKAY);
        stop_test;
    end
endmodule
`default_nettype wire
